// file: rtl/mmel_map.vh
`ifndef MMEL_MAP_VH
`define MMEL_MAP_VH

// Latched operating modes
`define MMEL_MODE_USER 2'h0
`define MMEL_MODE_NORMAL 2'h1
`define MMEL_MODE_FORCED_EXT 2'h2
`define MMEL_MODE_FORCED_INT 2'h3

// Erased flash byte
`define MMEL_ERASED_BYTE 8'hff

// Bit periods in bus cycles
`define MMEL_BIT_EXT 9'h100
`define MMEL_BIT_INT 9'h14f

// Character framing
`define MMEL_DATA_BITS 4'h8
`define MMEL_CHAR_BITS 4'ha
`define MMEL_BREAK_BITS 4'hb
`define MMEL_GAP_BITS 4'h2
`define MMEL_STOP_BIT 4'h9

// Security handshake length
`define MMEL_SEC_BYTES 4'h8

// Transmit FIFO geometry
`define MMEL_FIFO_WIDTH 8
`define MMEL_FIFO_DEPTH 16
`define MMEL_FIFO_AW 4

// Link states
`define MMEL_ST_IDLE 3'h0
`define MMEL_ST_SECURE 3'h1
`define MMEL_ST_SEND_BRK 3'h2
`define MMEL_ST_READY 3'h3
`define MMEL_ST_GAP 3'h4
`define MMEL_ST_ECHO 3'h5

`endif

// file: rtl/mmel_fifo.v
`timescale 1ns/1ns
`default_nettype none

module mmel_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 16,
    parameter AW = 4
) (
    input wire core_clk_i,
    input wire resetn_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [WIDTH-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [WIDTH-1:0] out_data_o
);

    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0] wr_ptr_r;
    reg [AW-1:0] rd_ptr_r;
    reg [AW:0] count_r;
    wire push;
    wire pop;

    assign in_ready_o = (count_r != DEPTH[AW:0]);
    assign out_valid_o = (count_r != {(AW+1){1'b0}});
    assign out_data_o = mem_r[rd_ptr_r];
    assign push = in_valid_i & in_ready_o;
    assign pop = out_valid_o & out_ready_i;

    ////////////////////////////////////////////////////////////////////////
    // Storage
    always @(posedge core_clk_i) begin
        if (push) begin
            mem_r[wr_ptr_r] <= in_data_i;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Pointers and fill level
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            wr_ptr_r <= {AW{1'b0}};
            rd_ptr_r <= {AW{1'b0}};
            count_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_ptr_r <= wr_ptr_r + 1'b1;
            end
            if (pop) begin
                rd_ptr_r <= rd_ptr_r + 1'b1;
            end
            if (push & ~pop) begin
                count_r <= count_r + 1'b1;
            end else if (pop & ~push) begin
                count_r <= count_r - 1'b1;
            end
        end
    end

endmodule // mmel_fifo

`default_nettype wire

// file: rtl/mmel_link.v
// Behaviour
// [RULE1] One shared wired-OR serial pin, pulled high
// [RULE2] NRZ mark/space character framing
// [RULE3] No test voltage: entry needs erased vector
// [RULE4] Monitor entry only after power-on reset
// [RULE5] Host drives test voltage, selects 1/0, clock
// [RULE6] Erased, interrupt low: internal trimmed oscillator
// [RULE7] Internal oscillator option needs erased vector
// [RULE8] Host keeps interrupt pin low, internal session
// [RULE9] Bit period 256 external, 335 internal
// [RULE10] Erased, interrupt high: forced external monitor
// [RULE11] Mode latched on internal reset rising edge
// [RULE12] Later mode-select changes ignored
// [RULE13] Receive eight security bytes first
// [RULE14] Then send ten-low-bit break character
// [RULE15] Received break: two high bits, echo
// [RULE16] Watchdog disabled during forced monitor
// [RULE17] Start, eight data LSB first, stop
`timescale 1ns/1ns
`default_nettype none
`include "mmel_map.vh"

module mmel_link (
    input wire core_clk_i,
    input wire resetn_i,
    input wire int_reset_n_i,
    input wire test_high_voltage_i,
    input wire irq_pin_i,
    input wire mode_select_a_pin_i,
    input wire mode_select_b_pin_i,
    input wire [7:0] vector_hi_i,
    input wire [7:0] vector_lo_i,
    input wire [7:0] oscillator_trim_value_i,
    input wire serial_comm_pin_i,
    output wire serial_comm_pin_o,
    output wire serial_comm_pin_oe_o,
    input wire tx_valid_i,
    output wire tx_ready_o,
    input wire [7:0] tx_data_i,
    output wire [7:0] rx_data_o,
    output wire rx_valid_o,
    output wire [1:0] mode_o,
    output wire monitor_active_o,
    output wire use_internal_osc_o,
    output wire apply_trim_o,
    output wire [7:0] oscillator_trim_o,
    output wire watchdog_disable_o,
    output wire security_done_o,
    output wire comm_lost_o,
    output wire [2:0] link_state_o
);

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers
    reg [4:0] pin_meta_r;
    reg [4:0] pin_sync_r;
    reg rx_prev_r;
    wire tv_s;
    wire irq_s;
    wire sel_a_s;
    wire sel_b_s;
    wire rx_s;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            pin_meta_r <= 5'h12;
            pin_sync_r <= 5'h12;
            rx_prev_r <= 1'b1;
        end else begin
            pin_meta_r <= {serial_comm_pin_i, mode_select_b_pin_i, mode_select_a_pin_i,
                irq_pin_i, test_high_voltage_i};
            pin_sync_r <= pin_meta_r;
            rx_prev_r <= pin_sync_r[4];
        end
    end
    assign tv_s = pin_sync_r[0];
    assign irq_s = pin_sync_r[1];
    assign sel_a_s = pin_sync_r[2];
    assign sel_b_s = pin_sync_r[3];
    assign rx_s = pin_sync_r[4];

    ////////////////////////////////////////////////////////////////////////
    // Mode latch
    reg [1:0] mode_r;
    reg [1:0] mode_nxt;
    reg armed_r;
    reg latched_r;
    reg int_rst_d_r;
    reg [7:0] trim_r;
    wire vec_blank;
    wire latch_now;
    // [RULE3] Blank vector check
    assign vec_blank = (vector_hi_i == `MMEL_ERASED_BYTE) && (vector_lo_i == `MMEL_ERASED_BYTE);
    // [RULE11] Internal reset edge
    assign latch_now = int_reset_n_i & ~int_rst_d_r & armed_r;
    always @* begin
        mode_nxt = `MMEL_MODE_USER;
        if (tv_s) begin
            // [RULE5] Normal entry selects
            if (sel_a_s & ~sel_b_s) begin
                mode_nxt = `MMEL_MODE_NORMAL;
            end
        end else if (vec_blank) begin
            // [RULE10] Forced external clock
            if (irq_s) begin
                mode_nxt = `MMEL_MODE_FORCED_EXT;
            // [RULE7] Internal only when blank
            end else begin
                mode_nxt = `MMEL_MODE_FORCED_INT;
            end
        end
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            // [RULE4] Only power-on reset arms entry
            armed_r <= 1'b1;
            latched_r <= 1'b0;
            mode_r <= `MMEL_MODE_USER;
            int_rst_d_r <= 1'b0;
            trim_r <= 8'h00;
        end else begin
            int_rst_d_r <= int_reset_n_i;
            // [RULE12] Held after one latch
            if (latch_now) begin
                mode_r <= mode_nxt;
                armed_r <= 1'b0;
                latched_r <= 1'b1;
                trim_r <= oscillator_trim_value_i;
            end
        end
    end

    wire monitor = latched_r && (mode_r != `MMEL_MODE_USER);
    wire forced = (mode_r == `MMEL_MODE_FORCED_EXT) || (mode_r == `MMEL_MODE_FORCED_INT);

    ////////////////////////////////////////////////////////////////////////
    // Bit timing
    wire [8:0] bit_len;
    wire [8:0] half_len;
    // [RULE9] Bit period by clock source
    assign bit_len = (mode_r == `MMEL_MODE_FORCED_INT) ? `MMEL_BIT_INT : `MMEL_BIT_EXT;
    assign half_len = {1'b0, bit_len[8:1]};

    ////////////////////////////////////////////////////////////////////////
    // Receiver
    reg [2:0] state_r;
    reg tx_busy_r;
    reg rx_busy_r;
    reg [8:0] rx_cnt_r;
    reg [3:0] rx_bits_r;
    reg [7:0] rx_shift_r;
    reg [7:0] rx_byte_r;
    reg rx_done_r;
    reg rx_break_r;
    wire rx_enable;
    wire rx_start;
    assign rx_enable = monitor && !tx_busy_r &&
        ((state_r == `MMEL_ST_SECURE) || (state_r == `MMEL_ST_READY));
    assign rx_start = rx_enable && !rx_busy_r && rx_prev_r && !rx_s;
    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rx_busy_r <= 1'b0;
            rx_cnt_r <= 9'h000;
            rx_bits_r <= 4'h0;
            rx_shift_r <= 8'h00;
            rx_byte_r <= 8'h00;
            rx_done_r <= 1'b0;
            rx_break_r <= 1'b0;
        end else begin
            rx_done_r <= 1'b0;
            rx_break_r <= 1'b0;
            if (rx_start) begin
                rx_busy_r <= 1'b1;
                rx_cnt_r <= half_len;
                rx_bits_r <= 4'h0;
            end else if (rx_busy_r) begin
                if (rx_cnt_r != 9'h001) begin
                    rx_cnt_r <= rx_cnt_r - 9'h001;
                end else begin
                    rx_cnt_r <= bit_len;
                    rx_bits_r <= rx_bits_r + 4'h1;
                    if (rx_bits_r == 4'h0) begin
                        if (rx_s) begin
                            rx_busy_r <= 1'b0;
                        end
                    end else if (rx_bits_r != `MMEL_STOP_BIT) begin
                        // [RULE17] Least significant bit first
                        rx_shift_r <= {rx_s, rx_shift_r[7:1]};
                    end else begin
                        // [RULE2] Stop bit closes character
                        rx_busy_r <= 1'b0;
                        rx_byte_r <= rx_shift_r;
                        rx_done_r <= 1'b1;
                        // [RULE15] Low stop with zero data
                        rx_break_r <= ~rx_s && (rx_shift_r == 8'h00);
                    end
                end
            end
        end
    end

    assign rx_data_o = rx_byte_r;
    assign rx_valid_o = rx_done_r;

    ////////////////////////////////////////////////////////////////////////
    // Transmit FIFO
    wire fifo_valid;
    wire [7:0] fifo_data;
    wire fifo_pop;

    mmel_fifo #(
        .WIDTH(`MMEL_FIFO_WIDTH),
        .DEPTH(`MMEL_FIFO_DEPTH),
        .AW(`MMEL_FIFO_AW)
    ) u_tx_fifo (
        .core_clk_i(core_clk_i),
        .resetn_i(resetn_i),
        .in_valid_i(tx_valid_i),
        .in_ready_o(tx_ready_o),
        .in_data_i(tx_data_i),
        .out_valid_o(fifo_valid),
        .out_ready_i(fifo_pop),
        .out_data_o(fifo_data)
    );

    ////////////////////////////////////////////////////////////////////////
    // Link sequencer
    reg [2:0] state_nxt;
    reg [3:0] sec_cnt_r;
    reg tx_load;
    reg [10:0] tx_load_pat;
    reg [3:0] tx_load_len;
    reg tx_load_hi;

    assign fifo_pop = (state_r == `MMEL_ST_READY) && !tx_busy_r && !rx_busy_r &&
        !rx_done_r && fifo_valid;

    always @* begin
        state_nxt = state_r;
        tx_load = 1'b0;
        tx_load_pat = 11'h7ff;
        tx_load_len = `MMEL_CHAR_BITS;
        tx_load_hi = 1'b0;
        case (state_r)
            `MMEL_ST_IDLE: begin
                if (monitor) begin
                    state_nxt = `MMEL_ST_SECURE;
                end
            end
            `MMEL_ST_SECURE: begin
                // [RULE13] Wait for all security bytes
                if (rx_done_r && (sec_cnt_r == `MMEL_SEC_BYTES - 4'h1)) begin
                    state_nxt = `MMEL_ST_SEND_BRK;
                end
            end
            `MMEL_ST_SEND_BRK: begin
                // [RULE14] Ten low bits then stop
                tx_load = 1'b1;
                tx_load_pat = 11'h400;
                tx_load_len = `MMEL_BREAK_BITS;
                state_nxt = `MMEL_ST_READY;
            end
            `MMEL_ST_READY: begin
                if (rx_break_r) begin
                    state_nxt = `MMEL_ST_GAP;
                end else if (fifo_pop) begin
                    // [RULE17] Start, data, stop
                    tx_load = 1'b1;
                    tx_load_pat = {2'h3, fifo_data, 1'b0};
                end
            end
            `MMEL_ST_GAP: begin
                // [RULE15] Drive high two bit times
                if (!tx_busy_r) begin
                    tx_load = 1'b1;
                    tx_load_pat = 11'h7ff;
                    tx_load_len = `MMEL_GAP_BITS;
                    tx_load_hi = 1'b1;
                    state_nxt = `MMEL_ST_ECHO;
                end
            end
            `MMEL_ST_ECHO: begin
                // [RULE15] Echo the break back
                if (!tx_busy_r) begin
                    tx_load = 1'b1;
                    tx_load_pat = 11'h400;
                    tx_load_len = `MMEL_BREAK_BITS;
                    state_nxt = `MMEL_ST_READY;
                end
            end
            default: begin
                state_nxt = `MMEL_ST_IDLE;
            end
        endcase
    end

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            state_r <= `MMEL_ST_IDLE;
            sec_cnt_r <= 4'h0;
        end else begin
            state_r <= state_nxt;
            // [RULE13] Count security bytes
            if ((state_r == `MMEL_ST_SECURE) && rx_done_r) begin
                sec_cnt_r <= sec_cnt_r + 4'h1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Transmitter
    reg [10:0] tx_pat_r;
    reg [3:0] tx_left_r;
    reg [8:0] tx_cnt_r;
    reg tx_hi_r;

    always @(posedge core_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            tx_busy_r <= 1'b0;
            tx_pat_r <= 11'h7ff;
            tx_left_r <= 4'h0;
            tx_cnt_r <= 9'h000;
            tx_hi_r <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_busy_r <= 1'b1;
                tx_pat_r <= tx_load_pat;
                tx_left_r <= tx_load_len;
                tx_cnt_r <= bit_len;
                tx_hi_r <= tx_load_hi;
            end else if (tx_busy_r) begin
                if (tx_cnt_r != 9'h001) begin
                    tx_cnt_r <= tx_cnt_r - 9'h001;
                end else begin
                    tx_cnt_r <= bit_len;
                    tx_pat_r <= {1'b1, tx_pat_r[10:1]};
                    tx_left_r <= tx_left_r - 4'h1;
                    if (tx_left_r == 4'h1) begin
                        tx_busy_r <= 1'b0;
                        tx_hi_r <= 1'b0;
                    end
                end
            end
        end
    end

    // [RULE1] Pull low only, except the high gap
    assign serial_comm_pin_o = tx_pat_r[0];
    assign serial_comm_pin_oe_o = tx_busy_r & (tx_hi_r | ~tx_pat_r[0]);

    ////////////////////////////////////////////////////////////////////////
    // Clock, trim, watchdog and status
    // [RULE6] Internal oscillator with stored trim
    assign use_internal_osc_o = monitor && (mode_r == `MMEL_MODE_FORCED_INT);
    assign apply_trim_o = use_internal_osc_o;
    assign oscillator_trim_o = trim_r;
    // [RULE16] Watchdog off in forced monitor
    assign watchdog_disable_o = monitor &&
        (forced || ((mode_r == `MMEL_MODE_NORMAL) && tv_s));
    // [RULE8] Interrupt pin high flags lost session
    assign comm_lost_o = use_internal_osc_o && irq_s;
    assign mode_o = mode_r;
    assign monitor_active_o = monitor;
    assign security_done_o = (state_r != `MMEL_ST_IDLE) && (state_r != `MMEL_ST_SECURE);
    assign link_state_o = state_r;

endmodule // mmel_link

`default_nettype wire

// file: bench/mmel_link_checker.sv
`timescale 1ns/1ns
`default_nettype none
module mmel_link_checker (
    input wire logic core_clk_i,
    input wire logic resetn_i,
    input wire logic irq_pin_i,
    input wire logic serial_comm_pin_o,
    input wire logic serial_comm_pin_oe_o,
    input wire logic rx_valid_o,
    input wire logic [1:0] mode_o,
    input wire logic monitor_active_o,
    input wire logic use_internal_osc_o,
    input wire logic apply_trim_o,
    input wire logic watchdog_disable_o,
    input wire logic security_done_o,
    input wire logic comm_lost_o,
    input wire logic [2:0] link_state_o
);
wire [9:0] bp = (mode_o == 2'h3) ? 10'h14f : 10'h100;
logic [12:0] low_n_r;
logic [10:0] gap_n_r;
// Lengths of driven-low runs and of driven-high runs
always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
        low_n_r <= 13'h0;
        gap_n_r <= 11'h0;
    end else begin
        low_n_r <= (serial_comm_pin_oe_o && !serial_comm_pin_o) ? low_n_r + 13'h1 : 13'h0;
        gap_n_r <= (serial_comm_pin_oe_o && serial_comm_pin_o) ? gap_n_r + 11'h1 : 11'h0;
    end
end
default clocking cb @(posedge core_clk_i);
endclocking
default disable iff (!resetn_i);
mode_hold_a: assert property (monitor_active_o |=> monitor_active_o && $stable(mode_o))
    else $error("mode changed after latch");
int_osc_a: assert property (use_internal_osc_o == (monitor_active_o && mode_o == 2'h3))
    else $error("internal oscillator select wrong");
trim_use_a: assert property (apply_trim_o == use_internal_osc_o)
    else $error("trim apply differs from oscillator select");
forced_wdog_a: assert property (mode_o[1] |-> watchdog_disable_o)
    else $error("watchdog active in forced monitor");
user_idle_a: assert property (!monitor_active_o |->
    link_state_o == 3'h0 && !serial_comm_pin_oe_o)
    else $error("link active outside monitor mode");
secure_first_a: assert property (!security_done_o |-> !serial_comm_pin_oe_o)
    else $error("pin driven before security bytes");
break_start_a: assert property (link_state_o == 3'h2 |=>
    serial_comm_pin_oe_o && !serial_comm_pin_o)
    else $error("break did not start");
low_run_a: assert property (low_n_r <= 10 * bp)
    else $error("low run longer than ten bits");
gap_drive_a: assert property (link_state_o == 3'h4 |=>
    serial_comm_pin_oe_o && serial_comm_pin_o)
    else $error("gap not driven high");
gap_len_a: assert property ($fell(serial_comm_pin_oe_o && serial_comm_pin_o) |->
    gap_n_r >= 2 * bp - 1 && gap_n_r <= 2 * bp + 1)
    else $error("gap length wrong");
rx_pulse_a: assert property (rx_valid_o |=> !rx_valid_o)
    else $error("receive strobe longer than one cycle");
lost_flag_a: assert property (
    comm_lost_o == (use_internal_osc_o && $past(irq_pin_i, 2)))
    else $error("comm lost flag differs from interrupt pin");
endmodule // mmel_link_checker
bind mmel_link mmel_link_checker i_chk (.core_clk_i(core_clk_i), .resetn_i(resetn_i),
    .irq_pin_i(irq_pin_i),
    .serial_comm_pin_o(serial_comm_pin_o), .serial_comm_pin_oe_o(serial_comm_pin_oe_o),
    .rx_valid_o(rx_valid_o), .mode_o(mode_o), .monitor_active_o(monitor_active_o),
    .use_internal_osc_o(use_internal_osc_o), .apply_trim_o(apply_trim_o),
    .watchdog_disable_o(watchdog_disable_o), .security_done_o(security_done_o),
    .comm_lost_o(comm_lost_o), .link_state_o(link_state_o));
`default_nettype wire

// file: bench/mmel_host.sv
`timescale 1ns/1ns
`default_nettype none
module mmel_host (
    input wire logic clk_i,
    input wire logic line_i,
    output logic drive_low_o
);
int bp = 256;
initial drive_low_o = 1'b0;
task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
endtask
task automatic send(input logic [7:0] d, input logic brk);
    @(posedge clk_i);
    drive_low_o <= 1'b1;
    tick(bp);
    for (int i = 0; i < 8; i++) begin
        drive_low_o <= brk | ~d[i];
        tick(bp);
    end
    drive_low_o <= brk;
    tick(bp);
    drive_low_o <= 1'b0;
    tick(bp);
endtask
task automatic get(output logic [7:0] d);
    wait (line_i === 1'b0);
    tick(bp / 2);
    for (int i = 0; i < 8; i++) begin
        tick(bp);
        d[i] = line_i;
    end
    wait (line_i === 1'b1);
endtask
task automatic low_len(output int n);
    n = 0;
    wait (line_i === 1'b0);
    while (line_i === 1'b0) begin
        @(posedge clk_i);
        #1;
        n++;
    end
endtask
endmodule // mmel_host
`default_nettype wire

// file: bench/mmel_link_tb.sv
`timescale 1ns/1ns
`default_nettype none
module mmel_link_tb;
logic core_clk_i = 1'b0, resetn_i = 1'b0, int_reset_n_i = 1'b0, test_high_voltage_i = 1'b0;
logic irq_pin_i = 1'b0, mode_select_a_pin_i = 1'b0, mode_select_b_pin_i = 1'b0;
logic tx_valid_i = 1'b0;
logic [7:0] vector_hi_i = 8'hff, vector_lo_i = 8'hff, tx_data_i = 8'h0;
logic [7:0] oscillator_trim_value_i = 8'h5a;
wire serial_comm_pin_i, serial_comm_pin_o, serial_comm_pin_oe_o, tx_ready_o, rx_valid_o;
wire monitor_active_o, use_internal_osc_o, apply_trim_o, watchdog_disable_o;
wire security_done_o, comm_lost_o, host_low;
wire [7:0] rx_data_o, oscillator_trim_o;
wire [1:0] mode_o;
wire [2:0] link_state_o;
int n_mismatch = 0, checked = 0, cyc = 0;
assign serial_comm_pin_i = !(host_low || (serial_comm_pin_oe_o && !serial_comm_pin_o));
mmel_link i_dut (.core_clk_i(core_clk_i), .resetn_i(resetn_i), .int_reset_n_i(int_reset_n_i),
    .test_high_voltage_i(test_high_voltage_i), .irq_pin_i(irq_pin_i),
    .mode_select_a_pin_i(mode_select_a_pin_i), .mode_select_b_pin_i(mode_select_b_pin_i),
    .vector_hi_i(vector_hi_i), .vector_lo_i(vector_lo_i),
    .oscillator_trim_value_i(oscillator_trim_value_i), .serial_comm_pin_i(serial_comm_pin_i),
    .serial_comm_pin_o(serial_comm_pin_o), .serial_comm_pin_oe_o(serial_comm_pin_oe_o),
    .tx_valid_i(tx_valid_i), .tx_ready_o(tx_ready_o), .tx_data_i(tx_data_i),
    .rx_data_o(rx_data_o), .rx_valid_o(rx_valid_o), .mode_o(mode_o),
    .monitor_active_o(monitor_active_o), .use_internal_osc_o(use_internal_osc_o),
    .apply_trim_o(apply_trim_o), .oscillator_trim_o(oscillator_trim_o),
    .watchdog_disable_o(watchdog_disable_o), .security_done_o(security_done_o),
    .comm_lost_o(comm_lost_o), .link_state_o(link_state_o));
mmel_host i_host (.clk_i(core_clk_i), .line_i(serial_comm_pin_i), .drive_low_o(host_low));
////////////////////////////////////////////////////////////////////////////////////////////
task automatic stop_test();
    $display("checked=%0d n_mismatch=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
        $display("No errors found");
    else
        $display("Errors were found");
    $finish;
endtask
task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp) begin
        n_mismatch++;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
endtask
task automatic por(input logic [5:0] c);
    resetn_i <= 1'b0;
    int_reset_n_i <= 1'b0;
    {test_high_voltage_i, irq_pin_i, mode_select_a_pin_i, mode_select_b_pin_i} <= c[5:2];
    vector_hi_i <= c[1] ? 8'hff : 8'h3c;
    vector_lo_i <= c[0] ? 8'hff : 8'hc3;
    repeat (16) @(posedge core_clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge core_clk_i);
    int_reset_n_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
endtask
task automatic rx_one(input logic [7:0] d, input logic tail);
    int n;
    fork
        i_host.send(d, 1'b0);
    join_none
    n = 0;
    while (rx_valid_o !== 1'b1 && n < 4000) begin
        @(posedge core_clk_i);
        n++;
    end
    chk(rx_data_o, d);
    chk(n >= 9 * i_host.bp && n <= 10 * i_host.bp, 1'b1);
    if (!tail)
        wait fork;
endtask
task automatic t_modes();
    logic [5:0] cs [6] = '{6'h38, 6'h23, 6'h17, 6'h03, 6'h02, 6'h11};
    logic [1:0] em [6] = '{2'h1, 2'h0, 2'h2, 2'h3, 2'h0, 2'h0};
    for (int i = 0; i < 6; i++) begin
        por(cs[i]);
        chk(mode_o, em[i]);
        chk(monitor_active_o, em[i] != 2'h0);
        chk(use_internal_osc_o, em[i] == 2'h3);
        chk(watchdog_disable_o, em[i] != 2'h0);
    end
endtask
task automatic t_session();
    int n;
    logic [7:0] d;
    por(6'h17);
    {test_high_voltage_i, mode_select_a_pin_i, mode_select_b_pin_i} <= 3'h6;
    int_reset_n_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    int_reset_n_i <= 1'b1;
    test_high_voltage_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    chk(mode_o, 2'h2);
    for (int i = 0; i < 16; i++) begin
        tx_valid_i <= 1'b1;
        tx_data_i <= 8'h30 + i[7:0];
        @(posedge core_clk_i);
    end
    tx_valid_i <= 1'b0;
    @(posedge core_clk_i);
    chk(tx_ready_o, 1'b0);
    for (int i = 0; i < 8; i++)
        rx_one(8'ha0 + i[7:0], i == 7);
    i_host.low_len(n);
    chk(n, 16'ha00);
    chk(security_done_o, 1'b1);
    for (int i = 0; i < 16; i++) begin
        i_host.get(d);
        chk(d, 8'h30 + i[7:0]);
    end
    chk(tx_ready_o, 1'b1);
    i_host.tick(512);
    i_host.send(8'h00, 1'b1);
    i_host.low_len(n);
    chk(n, 16'ha00);
endtask
task automatic t_int();
    por(6'h03);
    i_host.bp = 335;
    chk(oscillator_trim_o, 8'h5a);
    chk(apply_trim_o, 1'b1);
    rx_one(8'h5c, 1'b0);
    chk(comm_lost_o, 1'b0);
    irq_pin_i <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    chk(comm_lost_o, 1'b1);
endtask
always #10 core_clk_i = ~core_clk_i;
always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 90000) begin
        n_mismatch++;
        stop_test();
    end
end
initial begin
    t_modes();
    t_session();
    t_int();
    stop_test();
end
endmodule // mmel_link_tb
`default_nettype wire
